// >>> common/toc_pkg.sv
// constants shared by both ends of the timer output compare link
// assumes one 50 MHz clock and an active-low asynchronous reset
package toc_pkg;
	// ********************************
	// device byte map on the 8-bit bus
	// ********************************
	localparam logic [4:0] CNT_LO_ADDR   = 5'h00;
	localparam logic [4:0] CNT_HI_ADDR   = 5'h01;
	localparam logic [4:0] CMP_BASE_ADDR = 5'h02;
	localparam logic [4:0] CTRL_ADDR     = 5'h08;
	localparam logic [4:0] ACTION_ADDR   = 5'h09;
	localparam logic [4:0] IRQEN_ADDR    = 5'h0A;
	localparam logic [4:0] FLAGS_ADDR    = 5'h0B;
	localparam logic [4:0] FORCE_ADDR    = 5'h0C;
	localparam logic [4:0] PINDIR_ADDR   = 5'h0D;
	localparam logic [4:0] PORTVAL_ADDR  = 5'h0E;
	// ********************************
	// waveform modes and tops
	// ********************************
	localparam logic [3:0]  WGM_NORMAL     = 4'h0;
	localparam logic [3:0]  WGM_CTC_A      = 4'h4;
	localparam logic [3:0]  WGM_CTC_CAP    = 4'hC;
	localparam logic [3:0]  WGM_FAST_8     = 4'h5;
	localparam logic [3:0]  WGM_FAST_9     = 4'h6;
	localparam logic [3:0]  WGM_FAST_10    = 4'h7;
	localparam logic [3:0]  WGM_FAST_A     = 4'hF;
	localparam logic [15:0] TOP_MAX        = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT       = 16'h00FF;
	localparam logic [15:0] TOP_9BIT       = 16'h01FF;
	localparam logic [15:0] TOP_10BIT      = 16'h03FF;
	localparam logic [1:0]  ACT_NONE       = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE     = 2'h1;
	localparam logic [1:0]  ACT_CLEAR      = 2'h2;
	localparam logic [1:0]  ACT_SET        = 2'h3;
	localparam int          CH_COUNT       = 2;
	localparam int          PRESCALE       = 1;
	// ********************************
	// controller apb map
	// ********************************
	localparam logic [11:0] APB_CMD_ADDR    = 12'h000;
	localparam logic [11:0] APB_STATUS_ADDR = 12'h004;
	localparam logic [11:0] APB_ACK_ADDR    = 12'h008;
	localparam int          CMD_WRITE_BIT   = 16;
	localparam int          CMD_ADDR_POS    = 8;
endpackage : toc_pkg

// >>> common/toc_if.sv
// link between the cpu-side controller and the timer compare device
// assumes both ends share pclk
`timescale 1ns/10ps
interface toc_if #(parameter int NCH = toc_pkg::CH_COUNT);
	logic [4:0]     cpu_addr;
	logic [7:0]     cpu_wdata;
	logic           cpu_wr;
	logic           cpu_rd;
	logic [7:0]     cpu_rdata;
	logic           cpu_rvalid;
	logic [NCH-1:0] irq_req;
	logic [NCH-1:0] irq_ack;

	modport dev (input cpu_addr, cpu_wdata, cpu_wr, cpu_rd, irq_ack,
		output cpu_rdata, cpu_rvalid, irq_req);
	modport cpu (output cpu_addr, cpu_wdata, cpu_wr, cpu_rd, irq_ack,
		input cpu_rdata, cpu_rvalid, irq_req);
endinterface : toc_if

// >>> src/toc_device.sv
// output compare channels of a 16-bit timer/counter
// assumes a cpu end that writes high byte before low byte
// What this block does
// - compare full count with each compare register
// - match flag set one timer tick later
// - enabled flag raises interrupt request
// - flag cleared by service or writing one
// - channel A may define counter top
// - pwm modes double buffer, others bypass
// - cpu accesses buffer when buffering active
// - compare changed only by writes, direct read
// - high byte held, low write loads both
// - force strobe acts like match outside pwm, no flag
// - counter write blocks next tick's matches
// - counter written at top runs to max
// - software avoids writing bottom when downcounting
// - software presets state before pin direction
// - output state kept across mode changes
// - output action setting takes effect immediately
// - reset clears output state to zero
// - nonzero action overrides port pin value
// - action zero leaves state unchanged
// - action bits leave input capture alone
// - non-pwm actions toggle, clear or set
// - mode zero counts up, no clear
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
module toc_device #(
	parameter int NCH      = toc_pkg::CH_COUNT,
	parameter int PRESCALE = toc_pkg::PRESCALE
) (
	// clock and reset
	input  wire logic           pclk,
	input  wire logic           presetn,
	// cpu link
	toc_if.dev                  link,
	// compare pins
	output logic [NCH-1:0]      pin_out,
	output logic [NCH-1:0]      pin_oe_n
);
	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic [15:0]           cnt;
		logic [7:0]            temp;
		logic [NCH-1:0][15:0]  cmp;
		logic [NCH-1:0][15:0]  cbuf;
		logic [NCH-1:0][1:0]   action;
		logic [NCH-1:0]        pend;
		logic [NCH-1:0]        flag;
		logic [NCH-1:0]        ie;
		logic [NCH-1:0]        state;
		logic [NCH-1:0]        dir;
		logic [NCH-1:0]        portval;
		logic [3:0]            wgm;
		logic                  run;
		logic                  block;
		logic [15:0]           div;
		logic [7:0]            rdata;
		logic                  rvalid;
		logic [NCH-1:0]        irq;
		logic [NCH-1:0]        pin_out;
		logic [NCH-1:0]        pin_oe_n;
	} toc_dev_state_t;

	toc_dev_state_t s_reg;
	toc_dev_state_t s_next;

	// buffering only in the pwm modes
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = !(m == toc_pkg::WGM_NORMAL || m == toc_pkg::WGM_CTC_A
			|| m == toc_pkg::WGM_CTC_CAP);
	endfunction : is_pwm

	// capture-defined tops fall back to max: no capture register here
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a);
		unique case (m)
			toc_pkg::WGM_CTC_A,
			toc_pkg::WGM_FAST_A:  top_of = a;
			toc_pkg::WGM_FAST_8:  top_of = toc_pkg::TOP_8BIT;
			toc_pkg::WGM_FAST_9:  top_of = toc_pkg::TOP_9BIT;
			toc_pkg::WGM_FAST_10: top_of = toc_pkg::TOP_10BIT;
			default:              top_of = toc_pkg::TOP_MAX;
		endcase
	endfunction : top_of

	// ********************************
	// next state
	// ********************************
	always_comb
	begin
		logic             tick;
		logic             pwm;
		logic             at_top;
		logic [15:0]      top;
		logic [NCH-1:0]   match;
		logic [NCH-1:0]   fire;
		logic [4:0]       lo_addr;
		s_next = s_reg;
		tick = 1'b0;
		at_top = 1'b0;
		pwm = is_pwm(s_reg.wgm);
		top = top_of(s_reg.wgm, s_reg.cmp[0]);
		match = '0;
		fire = '0;
		lo_addr = '0;
		s_next.rvalid = 1'b0;
		if (s_reg.run)
		begin
			if (s_reg.div == 16'(PRESCALE - 1))
			begin
				s_next.div = '0;
				tick = 1'b1;
			end
			else
			begin
				s_next.div = s_reg.div + 16'h0001;
			end
		end
		at_top = tick && !s_reg.block && s_reg.cnt == top;
		for (int i = 0; i < NCH; i++)
		begin
			match[i] = tick && !s_reg.block && s_reg.cnt == s_reg.cmp[i];
		end
		// flag clears first so a coinciding set wins
		for (int i = 0; i < NCH; i++)
		begin
			if (link.irq_ack[i])
				s_next.flag[i] = 1'b0;
		end
		if (link.cpu_wr && link.cpu_addr == toc_pkg::FLAGS_ADDR)
			s_next.flag = s_next.flag & ~link.cpu_wdata[NCH-1:0];
		if (tick)
		begin
			s_next.flag = s_next.flag | s_reg.pend;
			s_next.pend = match;
			s_next.block = 1'b0;
			s_next.cnt = at_top ? 16'h0000 : s_reg.cnt + 16'h0001;
		end
		if (pwm && at_top)
			s_next.cmp = s_reg.cbuf;
		// waveform action, force only outside pwm
		for (int i = 0; i < NCH; i++)
		begin
			fire[i] = match[i] || (!pwm && link.cpu_wr && link.cpu_addr == toc_pkg::FORCE_ADDR
				&& link.cpu_wdata[i]);
			if (fire[i])
			begin
				unique case (s_reg.action[i])
					toc_pkg::ACT_NONE:   s_next.state[i] = s_reg.state[i];
					toc_pkg::ACT_TOGGLE: s_next.state[i] = !s_reg.state[i];
					toc_pkg::ACT_CLEAR:  s_next.state[i] = pwm;
					toc_pkg::ACT_SET:    s_next.state[i] = !pwm;
				endcase
			end
			else if (pwm && at_top && s_reg.action[i][1])
			begin
				s_next.state[i] = s_reg.action[i][0];
			end
		end
		// cpu writes override counting
		if (link.cpu_wr)
		begin
			unique case (link.cpu_addr)
				toc_pkg::CNT_HI_ADDR: s_next.temp = link.cpu_wdata;
				toc_pkg::CNT_LO_ADDR:
				begin
					s_next.cnt = {s_reg.temp, link.cpu_wdata};
					s_next.block = 1'b1;
				end
				toc_pkg::CTRL_ADDR:
				begin
					s_next.wgm = link.cpu_wdata[3:0];
					s_next.run = link.cpu_wdata[4];
				end
				toc_pkg::ACTION_ADDR:
				begin
					for (int i = 0; i < NCH; i++)
						s_next.action[i] = link.cpu_wdata[2*i +: 2];
				end
				toc_pkg::IRQEN_ADDR:   s_next.ie = link.cpu_wdata[NCH-1:0];
				toc_pkg::PINDIR_ADDR:  s_next.dir = link.cpu_wdata[NCH-1:0];
				toc_pkg::PORTVAL_ADDR: s_next.portval = link.cpu_wdata[NCH-1:0];
				default:
				begin
					for (int i = 0; i < NCH; i++)
					begin
						lo_addr = 5'(toc_pkg::CMP_BASE_ADDR + 2 * i);
						if (link.cpu_addr == lo_addr + 5'h01)
							s_next.temp = link.cpu_wdata;
						else if (link.cpu_addr == lo_addr && pwm)
							s_next.cbuf[i] = {s_reg.temp, link.cpu_wdata};
						else if (link.cpu_addr == lo_addr)
							s_next.cmp[i] = {s_reg.temp, link.cpu_wdata};
					end
				end
			endcase
		end
		// reads answer one cycle after the strobe
		if (link.cpu_rd)
		begin
			s_next.rvalid = 1'b1;
			s_next.rdata = 8'h00;
			unique case (link.cpu_addr)
				toc_pkg::CNT_LO_ADDR:
				begin
					s_next.rdata = s_reg.cnt[7:0];
					s_next.temp = s_reg.cnt[15:8];
				end
				toc_pkg::CNT_HI_ADDR:  s_next.rdata = s_reg.temp;
				toc_pkg::CTRL_ADDR:    s_next.rdata = {3'h0, s_reg.run, s_reg.wgm};
				toc_pkg::ACTION_ADDR:  s_next.rdata = 8'(s_reg.action);
				toc_pkg::IRQEN_ADDR:   s_next.rdata = 8'(s_reg.ie);
				toc_pkg::FLAGS_ADDR:   s_next.rdata = 8'(s_reg.flag);
				toc_pkg::PINDIR_ADDR:  s_next.rdata = 8'(s_reg.dir);
				toc_pkg::PORTVAL_ADDR: s_next.rdata = 8'(s_reg.portval);
				default:
				begin
					for (int i = 0; i < NCH; i++)
					begin
						lo_addr = 5'(toc_pkg::CMP_BASE_ADDR + 2 * i);
						if (link.cpu_addr == lo_addr)
							s_next.rdata = pwm ? s_reg.cbuf[i][7:0] : s_reg.cmp[i][7:0];
						else if (link.cpu_addr == lo_addr + 5'h01)
							s_next.rdata = pwm ? s_reg.cbuf[i][15:8] : s_reg.cmp[i][15:8];
					end
				end
			endcase
		end
		s_next.irq = s_next.flag & s_next.ie;
		// action bits only steer the pin, capture is untouched
		for (int i = 0; i < NCH; i++)
		begin
			s_next.pin_out[i] = (s_next.action[i] != toc_pkg::ACT_NONE) ?
				s_next.state[i] : s_next.portval[i];
			s_next.pin_oe_n[i] = !s_next.dir[i];
		end
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.pin_oe_n <= '1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign link.cpu_rdata  = s_reg.rdata;
	assign link.cpu_rvalid = s_reg.rvalid;
	assign link.irq_req    = s_reg.irq;
	assign pin_out         = s_reg.pin_out;
	assign pin_oe_n        = s_reg.pin_oe_n;
endmodule : toc_device

// >>> src/toc_controller.sv
// cpu-side end: apb registers turned into byte accesses on the link
// assumes the device answers every read with one rvalid pulse
`timescale 1ns/10ps
module toc_controller #(
	parameter int NCH = toc_pkg::CH_COUNT
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// device link
	toc_if.cpu               link
);
	// ********************************
	// state
	// ********************************
	typedef struct packed {
		logic [4:0]     addr;
		logic [7:0]     wdata;
		logic           wr;
		logic           rd;
		logic           busy;
		logic [7:0]     rdata;
		logic [NCH-1:0] ack;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
	} toc_ctl_state_t;

	toc_ctl_state_t s_reg;
	toc_ctl_state_t s_next;

	always_comb
	begin
		logic setup;
		s_next = s_reg;
		s_next.wr = 1'b0;
		s_next.rd = 1'b0;
		s_next.ack = '0;
		s_next.pready = 1'b1;
		setup = psel && !penable;
		if (link.cpu_rvalid)
		begin
			s_next.rdata = link.cpu_rdata;
			s_next.busy = 1'b0;
		end
		if (setup)
		begin
			s_next.pslverr = 1'b0;
			s_next.prdata = 32'h0000_0000;
			unique case (paddr)
				toc_pkg::APB_CMD_ADDR:
				begin
					// a command while busy is dropped; poll busy first
					if (pwrite && !s_reg.busy)
					begin
						s_next.addr = pwdata[toc_pkg::CMD_ADDR_POS +: 5];
						s_next.wdata = pwdata[7:0];
						s_next.wr = pwdata[toc_pkg::CMD_WRITE_BIT];
						s_next.rd = !pwdata[toc_pkg::CMD_WRITE_BIT];
						s_next.busy = !pwdata[toc_pkg::CMD_WRITE_BIT];
					end
					s_next.prdata = {15'h0000, s_reg.wr, 3'h0, s_reg.addr, s_reg.wdata};
				end
				toc_pkg::APB_STATUS_ADDR:
					s_next.prdata = {8'h00, 8'(link.irq_req), s_reg.rdata, 7'h00, s_reg.busy};
				toc_pkg::APB_ACK_ADDR:
				begin
					// service acknowledge clears the device flag
					if (pwrite)
						s_next.ack = pwdata[NCH-1:0];
				end
				default: s_next.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign link.cpu_addr  = s_reg.addr;
	assign link.cpu_wdata = s_reg.wdata;
	assign link.cpu_wr    = s_reg.wr;
	assign link.cpu_rd    = s_reg.rd;
	assign link.irq_ack   = s_reg.ack;
	assign prdata         = s_reg.prdata;
	assign pready         = s_reg.pready;
	assign pslverr        = s_reg.pslverr;
endmodule : toc_controller

// >>> sim/toc_checker_sva.sv
// link checker for the timer compare device and its cpu end
// assumes it watches the toc_if signals between the two ends
`timescale 1ns/10ps
module toc_checker_sva #(
	parameter int NCH = toc_pkg::CH_COUNT
) (
	// clock and reset
	input wire logic           pclk,
	input wire logic           presetn,
	// cpu link
	input wire logic [4:0]     cpu_addr,
	input wire logic [7:0]     cpu_wdata,
	input wire logic           cpu_wr,
	input wire logic           cpu_rd,
	input wire logic [7:0]     cpu_rdata,
	input wire logic           cpu_rvalid,
	input wire logic [NCH-1:0] irq_req,
	input wire logic [NCH-1:0] irq_ack
);
	// ****************
	// shadow registers
	// ****************
	logic [NCH-1:0] en_q;
	logic           run_q;
	logic [7:0]     temp_q;
	logic [15:0]    cmp_a_q;
	// counter low reads also load the holding byte; bench avoids them mid-pair
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_q    <= '0;
			run_q   <= 1'b0;
			temp_q  <= 8'h00;
			cmp_a_q <= 16'h0000;
		end
		else if (cpu_wr)
		begin
			case (cpu_addr)
				toc_pkg::IRQEN_ADDR:    en_q <= cpu_wdata[NCH-1:0];
				toc_pkg::CTRL_ADDR:     run_q <= cpu_wdata[4];
				5'h01, 5'h03, 5'h05:    temp_q <= cpu_wdata;
				toc_pkg::CMP_BASE_ADDR: cmp_a_q <= {temp_q, cpu_wdata};
				default:                ;
			endcase
		end
	end
	// **********
	// properties
	// **********
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rd_answer; cpu_rd |=> cpu_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_rvalid_cause; cpu_rvalid |-> $past(cpu_rd); endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("answer without read");
	property p_cmp_lo;
		cpu_rd && cpu_addr == toc_pkg::CMP_BASE_ADDR |=> cpu_rdata == cmp_a_q[7:0];
	endproperty
	a_cmp_lo: assert property (p_cmp_lo)
		else $error("compare low byte wrong");
	property p_cmp_hi;
		cpu_rd && cpu_addr == 5'h03 |=> cpu_rdata == cmp_a_q[15:8];
	endproperty
	a_cmp_hi: assert property (p_cmp_hi)
		else $error("compare high byte wrong");
	property p_force_zero;
		cpu_rd && cpu_addr == toc_pkg::FORCE_ADDR |=> cpu_rdata == 8'h00;
	endproperty
	a_force_zero: assert property (p_force_zero)
		else $error("force strobe reads nonzero");
	property p_irq_gate; irq_req[0] |-> en_q[0] || $past(en_q[0]); endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("request while disabled");
	property p_clear_one;
		cpu_wr && cpu_addr == toc_pkg::FLAGS_ADDR && cpu_wdata[0] && !run_q && !$past(run_q)
			|-> ##[1:2] !irq_req[0];
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("flag not cleared by one");
	property p_ack_clear; irq_ack[0] && !run_q && !$past(run_q) |-> ##[1:2] !irq_req[0];
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("flag not cleared by service");
	property p_zero_keeps;
		cpu_wr && cpu_addr == toc_pkg::FLAGS_ADDR && !cpu_wdata[0] && irq_req[0] |=> irq_req[0];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps)
		else $error("zero write cleared flag");
	c_irq: cover property (irq_req[0]);
	c_ack: cover property (irq_ack[0]);
	c_rd: cover property (cpu_rvalid && cpu_rdata != 8'h00);
endmodule : toc_checker_sva

// >>> sim/timer16_output_compare_tb_top.sv
// bench for controller and device joined over toc_if
// assumes pclk 50 MHz and software access through apb only
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module timer16_output_compare_tb_top;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe_n;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  b;
	int          miscompares = 0;
	int          cmp_count   = 0;
	logic [7:0]  acts [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
	logic        exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	// ***********
	// the devices
	// ***********
	toc_if link_if ();
	toc_controller toc_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link_if.cpu));
	toc_device toc_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if.dev),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n));
	toc_checker_sva toc_checker_sva_inst (.pclk(pclk), .presetn(presetn),
		.cpu_addr(link_if.cpu_addr), .cpu_wdata(link_if.cpu_wdata), .cpu_wr(link_if.cpu_wr),
		.cpu_rd(link_if.cpu_rd), .cpu_rdata(link_if.cpu_rdata),
		.cpu_rvalid(link_if.cpu_rvalid), .irq_req(link_if.irq_req), .irq_ack(link_if.irq_ack));
	always #10 pclk = ~pclk;
	// *****
	// tasks
	// *****
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic dw(input logic [4:0] a, input logic [7:0] d);
		apb(1'b1, toc_pkg::APB_CMD_ADDR, {15'h0000, 1'b1, 3'h0, a, d});
	endtask : dw
	// polling busy keeps the next command off the link until the answer lands
	task automatic dr(input logic [4:0] a);
		apb(1'b1, toc_pkg::APB_CMD_ADDR, {15'h0000, 1'b0, 3'h0, a, 8'h00});
		do apb(1'b0, toc_pkg::APB_STATUS_ADDR, 32'h0); while (rd[0] !== 1'b0);
		b = rd[15:8];
	endtask : dr
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	initial
	begin
		wt(20000);
		miscompares++;
		final_report();
	end
	// *****
	// tests
	// *****
	initial
	begin
		wt(12);
		presetn <= 1'b1;
		wt(1);
		`CHK(pin_out, 2'b00)
		apb(1'b1, 12'h010, 32'h0);
		`CHK(er, 1'b1)
		dw(5'h03, 8'h12); dw(5'h05, 8'hAB); dw(5'h02, 8'h10);
		dr(5'h02); `CHK(b, 8'h10)
		dr(5'h03); `CHK(b, 8'hAB)
		dw(5'h03, 8'h00); dw(5'h02, 8'h10);
		dr(5'h03); `CHK(b, 8'h00)
		dw(5'h09, 8'h02); dw(5'h0C, 8'h01);
		dw(5'h09, 8'h01); dw(5'h0A, 8'h01); dw(5'h0D, 8'h03); wt(3);
		`CHK(pin_oe_n, 2'b00)
		// counter written equal to compare, first tick must stay quiet
		dw(5'h01, 8'h00); dw(5'h00, 8'h10); dw(5'h08, 8'h10); wt(20); dw(5'h08, 8'h00);
		apb(1'b0, toc_pkg::APB_STATUS_ADDR, 32'h0);
		`CHK(rd[16], 1'b0)
		`CHK(pin_out[0], 1'b0)
		dw(5'h00, 8'h05); dw(5'h08, 8'h10); wt(30); dw(5'h08, 8'h00); wt(3);
		apb(1'b0, toc_pkg::APB_STATUS_ADDR, 32'h0);
		`CHK(rd[16], 1'b1)
		`CHK(pin_out[0], 1'b1)
		dw(5'h0B, 8'h00); dr(5'h0B); `CHK(b[0], 1'b1)
		dw(5'h0B, 8'h01); dr(5'h0B); `CHK(b[0], 1'b0)
		dw(5'h00, 8'h05); dw(5'h08, 8'h10); wt(30); dw(5'h08, 8'h00);
		apb(1'b1, toc_pkg::APB_ACK_ADDR, 32'h1); wt(3);
		apb(1'b0, toc_pkg::APB_STATUS_ADDR, 32'h0);
		`CHK(rd[16], 1'b0)
		`CHK(pin_out[0], 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			dw(5'h09, acts[i]); dw(5'h0C, 8'h01); wt(3);
			`CHK(pin_out[0], exps[i])
		end
		dr(5'h0B); `CHK(b[0], 1'b0)
		dw(5'h0E, 8'h01); dw(5'h09, 8'h00); dw(5'h0C, 8'h01); wt(3);
		`CHK(pin_out[0], 1'b1)
		dw(5'h09, 8'h01); wt(2);
		`CHK(pin_out[0], 1'b0)
		dw(5'h0C, 8'h01); wt(3); dw(5'h08, 8'h0F); wt(3);
		`CHK(pin_out[0], 1'b1)
		dw(5'h03, 8'h00); dw(5'h02, 8'h55);
		dr(5'h02); `CHK(b, 8'h55)
		// channel A as top: count must never pass 3
		dw(5'h08, 8'h04); dw(5'h03, 8'h00); dw(5'h02, 8'h03); dw(5'h00, 8'h00);
		dw(5'h08, 8'h14); wt(40); dw(5'h08, 8'h04);
		dr(5'h00); `CHK(b <= 8'h03, 1'b1)
		dr(5'h01); `CHK(b, 8'h00)
		// count written equal to register top: top lost, no buffer transfer
		dw(5'h08, 8'h0F); dw(5'h03, 8'h00); dw(5'h02, 8'h08); dw(5'h01, 8'h00);
		dw(5'h00, 8'h03); dw(5'h08, 8'h1F); wt(10); dw(5'h08, 8'h0F);
		dr(5'h00); `CHK(b > 8'h08, 1'b1)
		// buffered value reaches the active register only at top
		dw(5'h01, 8'h00); dw(5'h00, 8'h00); dw(5'h08, 8'h1F); wt(10); dw(5'h08, 8'h00);
		dr(5'h02); `CHK(b, 8'h08)
		final_report();
	end
endmodule : timer16_output_compare_tb_top
